// ===== inc/ifd_consts.svh
// constants for the instruction format and timing decoder
// ---------------------------------------------------------------
// What this block does
// - 24-bit word, 8-bit opcode picks type
// - exactly three opcodes span two words
// - two-word form: 48 bits, word two top zero
// - lone second word runs as no-operation
// - one cycle; true test or jump: two
// - branch, table, return ops take 2-3 cycles
// - taken skip: two or three cycles
// - two-word instructions take exactly two cycles
// - register ops decode base, source, destination
// - file ops decode address and destination
// - bit ops decode target and bit position
// - literal moves decode value and target
// - literal math: base, value, optional destination
// ---------------------------------------------------------------
`ifndef IFD_CONSTS_SVH
`define IFD_CONSTS_SVH

// ---------------------------------------------------------------
// word layout
// ---------------------------------------------------------------
`define IFD_WORD_W 24
`define IFD_OP_MSB 23
`define IFD_OP_LSB 16
`define IFD_OPER_W 16

// ---------------------------------------------------------------
// opcode map
// ---------------------------------------------------------------
`define IFD_OP_NOP 8'h00
`define IFD_OP_GOTO2 8'h02
`define IFD_OP_CALL2 8'h03
`define IFD_OP_MOVD2 8'h04
`define IFD_OP_BRANCH 8'h05
`define IFD_OP_INDJMP 8'h06
`define IFD_OP_TBLRD 8'h07
`define IFD_OP_TBLWR 8'h08
`define IFD_OP_RETURN 8'h09
`define IFD_OP_RETINT 8'h0a
`define IFD_GRP_FILE 4'h5
`define IFD_GRP_BIT 4'h6
`define IFD_GRP_LITMOV 4'h7
`define IFD_GRP_LITALU 4'h8
`define IFD_GRP_SKIP 4'h9
`define IFD_GRP_CTRL 4'h0

// ---------------------------------------------------------------
// cycle counts per instruction
// ---------------------------------------------------------------
`define IFD_CYC_COND 2'd2
`define IFD_CYC_BRANCH 2'd2
`define IFD_CYC_INDJMP 2'd2
`define IFD_CYC_TABLE 2'd2
`define IFD_CYC_RETURN 2'd3

`endif

// ===== inc/ifd_pkg.sv
// types shared by the instruction format and timing decoder
package ifd_pkg;

    // instruction category
    typedef enum logic [3:0] {
        CL_NOP = 4'h0,
        CL_WORD = 4'h1,
        CL_FILE = 4'h2,
        CL_BIT = 4'h3,
        CL_LITMOV = 4'h4,
        CL_LITALU = 4'h5,
        CL_SKIP = 4'h6,
        CL_TWOWORD = 4'h7,
        CL_BRANCH = 4'h8,
        CL_INDJMP = 4'h9,
        CL_TABLE = 4'ha,
        CL_RETURN = 4'hb
    } ifd_class_e;

    // address modifier of a register operand
    typedef enum logic [1:0] {
        MD_DIRECT = 2'h0,
        MD_INDIRECT = 2'h1,
        MD_POSTINC = 2'h2,
        MD_PREDEC = 2'h3
    } ifd_mode_e;

    // sequencer states, one-hot
    typedef enum logic [3:0] {
        S_FETCH = 4'b0001,
        S_SECOND = 4'b0010,
        S_NOP = 4'b0100,
        S_SKIP = 4'b1000
    } ifd_state_e;

    // decoded operand fields
    typedef struct packed {
        logic [7:0] opcode;
        ifd_class_e cls;
        logic [3:0] baseReg;
        logic [3:0] srcReg;
        ifd_mode_e srcMode;
        logic [3:0] dstReg;
        ifd_mode_e dstMode;
        logic [12:0] fileAddr;
        logic toAccum;
        logic [3:0] bitPos;
        logic bitIndirect;
        logic toFile;
        logic [15:0] literal;
    } ifd_fields_s;

endpackage

// ===== design/ifd_core.sv
// instruction format decoder and cycle sequencer
`timescale 1ns/1ps
`include "ifd_consts.svh"

module ifd_core (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [23:0] progWord,
    input wire logic progValid,
    input wire logic condTrue,
    input wire logic pcChange,
    input wire logic skipTaken,
    output logic fetchReady,
    output logic issueValid,
    output logic [7:0] issueOpcode,
    output ifd_pkg::ifd_class_e issueClass,
    output logic [3:0] base_source_reg,
    output logic [3:0] second_source_reg,
    output ifd_pkg::ifd_mode_e secondSourceMode,
    output logic [3:0] dest_reg,
    output ifd_pkg::ifd_mode_e destMode,
    output logic [12:0] fileAddr,
    output logic accumulator_alias,
    output logic [3:0] bitPos,
    output logic bitIndirect,
    output logic targetIsFile,
    output logic [15:0] literal,
    output logic [15:0] extOperand,
    output logic cycleNop,
    output logic secondBad
);
    import ifd_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    function automatic logic isTwo(input logic [7:0] op);
        isTwo = (op == `IFD_OP_GOTO2) || (op == `IFD_OP_CALL2) ||
            (op == `IFD_OP_MOVD2);
    endfunction

    // opcode to category; unlisted control codes act as no-op
    function automatic ifd_class_e classOf(input logic [7:0] op);
        classOf = CL_WORD;
        if (isTwo(op)) begin
            classOf = CL_TWOWORD;
        end else if (op[7:4] == `IFD_GRP_CTRL) begin
            unique case (op)
                `IFD_OP_BRANCH: classOf = CL_BRANCH;
                `IFD_OP_INDJMP: classOf = CL_INDJMP;
                `IFD_OP_TBLRD, `IFD_OP_TBLWR: classOf = CL_TABLE;
                `IFD_OP_RETURN, `IFD_OP_RETINT: classOf = CL_RETURN;
                default: classOf = CL_NOP;
            endcase
        end else if (op[7:4] == `IFD_GRP_FILE) begin
            classOf = CL_FILE;
        end else if (op[7:4] == `IFD_GRP_BIT) begin
            classOf = CL_BIT;
        end else if (op[7:4] == `IFD_GRP_LITMOV) begin
            classOf = CL_LITMOV;
        end else if (op[7:4] == `IFD_GRP_LITALU) begin
            classOf = CL_LITALU;
        end else if (op[7:4] == `IFD_GRP_SKIP) begin
            classOf = CL_SKIP;
        end
    endfunction

    // split one word into operand fields
    function automatic ifd_fields_s decode(input logic [23:0] w);
        ifd_fields_s f;
        f = '0;
        // opcode is the top eight bits
        f.opcode = w[`IFD_OP_MSB:`IFD_OP_LSB];
        f.cls = classOf(f.opcode);
        unique case (f.cls)
            CL_WORD, CL_SKIP: begin
                f.baseReg = w[15:12];
                f.dstReg = w[11:8];
                f.dstMode = ifd_mode_e'(w[7:6]);
                f.srcMode = ifd_mode_e'(w[5:4]);
                f.srcReg = w[3:0];
            end
            CL_FILE: begin
                f.toAccum = w[15];
                f.fileAddr = w[12:0];
            end
            CL_BIT: begin
                f.toFile = w[15];
                f.bitIndirect = w[14];
                f.bitPos = w[13:10];
                f.baseReg = w[13:10];
                f.fileAddr = {3'h0, w[9:0]};
                f.srcMode = ifd_mode_e'(w[5:4]);
                f.srcReg = w[3:0];
            end
            CL_LITMOV: begin
                f.toFile = w[15];
                f.literal = {5'h00, w[14:4]};
                f.dstReg = w[3:0];
                f.fileAddr = {9'h000, w[3:0]};
            end
            CL_LITALU: begin
                f.baseReg = w[15:12];
                f.literal = {11'h000, w[4:0]};
                if (w[5]) begin
                    f.dstReg = w[11:8];
                    f.dstMode = ifd_mode_e'(w[7:6]);
                end else begin
                    f.dstReg = w[15:12];
                    f.dstMode = MD_DIRECT;
                end
            end
            // control and two-word forms carry an address field
            default: begin
                f.literal = w[15:0];
            end
        endcase
        decode = f;
    endfunction

    // no-op cycles added after the issue cycle
    function automatic logic [1:0] extraOf(input ifd_class_e c,
            input logic cnd, input logic jmp);
        unique case (c)
            CL_BRANCH: extraOf = `IFD_CYC_BRANCH - 2'd1;
            CL_INDJMP: extraOf = `IFD_CYC_INDJMP - 2'd1;
            CL_TABLE: extraOf = `IFD_CYC_TABLE - 2'd1;
            CL_RETURN: extraOf = `IFD_CYC_RETURN - 2'd1;
            // a lone second word never pads, whatever the flags
            CL_NOP: extraOf = 2'd0;
            // true test or jump adds one
            default: extraOf = (cnd || jmp) ? `IFD_CYC_COND - 2'd1 : 2'd0;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // sequencer state
    // ---------------------------------------------------------------
    ifd_state_e state, next_state; // current phase
    logic [1:0] nopLeft, next_nopLeft; // pending no-op cycles
    logic [23:0] hold, next_hold; // first half of a long word
    logic skipTail, next_skipTail; // one more word to discard
    ifd_fields_s fld, next_fld; // issued fields
    logic [15:0] next_extOperand;
    logic next_issueValid, next_cycleNop, next_secondBad;
    logic next_fetchReady;
    logic take; // word accepted this cycle
    ifd_fields_s dec; // decode of the incoming word
    logic [1:0] extra;

    assign take = progValid && fetchReady;
    assign dec = decode(progWord);
    assign extra = extraOf(dec.cls, condTrue, pcChange);

    // next-state and output logic
    always_comb begin
        next_state = state;
        next_nopLeft = nopLeft;
        next_hold = hold;
        next_skipTail = skipTail;
        next_fld = fld;
        next_extOperand = extOperand;
        next_issueValid = 1'b0;
        next_secondBad = 1'b0;
        unique case (state)
            S_FETCH: begin
                if (take && isTwo(dec.opcode)) begin
                    // park the first word until its partner arrives
                    next_hold = progWord;
                    next_state = S_SECOND;
                end else if (take) begin
                    // opcode zero issues as a no-op
                    next_fld = dec;
                    next_extOperand = 16'h0000;
                    next_issueValid = 1'b1;
                    if (dec.cls == CL_SKIP && skipTaken) begin
                        next_state = S_SKIP;
                        next_skipTail = 1'b0;
                    end else if (extra != 2'd0) begin
                        next_nopLeft = extra;
                        next_state = S_NOP;
                    end
                end
            end
            S_SECOND: begin
                if (take) begin
                    // issue on the second of two cycles
                    next_fld = decode(hold);
                    next_extOperand = progWord[15:0];
                    next_issueValid = 1'b1;
                    // top byte of word two must be zero
                    next_secondBad = |progWord[`IFD_OP_MSB:`IFD_OP_LSB];
                    next_state = S_FETCH;
                end
            end
            S_NOP: begin
                next_nopLeft = nopLeft - 2'd1;
                if (nopLeft == 2'd1) begin
                    next_state = S_FETCH;
                end
            end
            S_SKIP: begin
                if (take) begin
                    // a skipped two-word form costs one more
                    if (!skipTail && isTwo(dec.opcode)) begin
                        next_skipTail = 1'b1;
                    end else begin
                        next_skipTail = 1'b0;
                        next_state = S_FETCH;
                    end
                end
            end
        endcase
        // ready is withheld only while padding with no-ops
        next_fetchReady = (next_state != S_NOP);
        next_cycleNop = (next_state == S_NOP) || (next_state == S_SKIP);
    end

    // state registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_FETCH;
            nopLeft <= 2'd0;
            hold <= 24'h000000;
            skipTail <= 1'b0;
            fld <= '0;
            extOperand <= 16'h0000;
            issueValid <= 1'b0;
            cycleNop <= 1'b0;
            secondBad <= 1'b0;
            fetchReady <= 1'b1;
        end else begin
            state <= next_state;
            nopLeft <= next_nopLeft;
            hold <= next_hold;
            skipTail <= next_skipTail;
            fld <= next_fld;
            extOperand <= next_extOperand;
            issueValid <= next_issueValid;
            cycleNop <= next_cycleNop;
            secondBad <= next_secondBad;
            fetchReady <= next_fetchReady;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from the field register
    // ---------------------------------------------------------------
    assign issueOpcode = fld.opcode;
    assign issueClass = fld.cls;
    assign base_source_reg = fld.baseReg;
    assign second_source_reg = fld.srcReg;
    assign secondSourceMode = fld.srcMode;
    assign dest_reg = fld.dstReg;
    assign destMode = fld.dstMode;
    assign fileAddr = fld.fileAddr;
    assign accumulator_alias = fld.toAccum;
    assign bitPos = fld.bitPos;
    assign bitIndirect = fld.bitIndirect;
    assign targetIsFile = fld.toFile;
    assign literal = fld.literal;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    opcode_field_a: assert property (
        take && state == S_FETCH && !isTwo(progWord[23:16])
        |=> issueValid && issueOpcode == $past(progWord[23:16]))
        else $error("issued opcode differs from word");

    two_word_a: assert property (
        take && state == S_FETCH |=>
        (state == S_SECOND) == isTwo($past(progWord[23:16])) &&
        issueValid == (state != S_SECOND))
        else $error("wrong word count for opcode");

    second_zero_a: assert property (
        take && state == S_SECOND && progWord[23:16] != 8'h00
        |=> secondBad && issueValid)
        else $error("nonzero second word not flagged");

    lone_nop_a: assert property (
        take && state == S_FETCH && progWord[23:16] == 8'h00
        |=> issueClass == CL_NOP && !cycleNop)
        else $error("zero opcode not a plain no-op");

    cond_extra_a: assert property (
        take && state == S_FETCH && (condTrue || pcChange) &&
        classOf(progWord[23:16]) inside {CL_WORD, CL_FILE, CL_BIT}
        |=> cycleNop && !fetchReady ##1 fetchReady && !cycleNop)
        else $error("true test did not add one cycle");

    return_cyc_a: assert property (
        take && state == S_FETCH && classOf(progWord[23:16]) == CL_RETURN
        |=> (!fetchReady)[*2] ##1 fetchReady)
        else $error("return did not take three cycles");

    skip_span_a: assert property (
        take && state == S_FETCH && skipTaken &&
        classOf(progWord[23:16]) == CL_SKIP
        |=> cycleNop && state == S_SKIP)
        else $error("taken skip did not discard");

    dword_issue_a: assert property (
        take && state == S_SECOND
        |=> issueValid && issueClass == CL_TWOWORD && fetchReady &&
        !cycleNop)
        else $error("two-word issue timing wrong");

    alu_dest_a: assert property (
        issueValid && issueClass == CL_LITALU && destMode == MD_DIRECT
        && dest_reg != base_source_reg |-> $past(progWord[5], 1))
        else $error("literal math destination misdecoded");

endmodule

// ===== sim/ifd_fetch_model.sv
// program memory fetch path model feeding the decoder
`timescale 1ns/1ps

module ifd_fetch_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic fetchReady,
    input wire logic start,
    input wire logic stall,
    input wire logic [26:0] prog [64],
    input wire logic [6:0] progLen,
    output logic [23:0] progWord,
    output logic progValid,
    output logic condTrue,
    output logic pcChange,
    output logic skipTaken
);
    logic took; // word accepted at the last rising edge
    logic bub; // bubble toggle for a slow supply
    logic [26:0] cur; // flags and word on offer
    logic [6:0] ptr; // entry now offered
    logic [6:0] nxt; // entry to offer next
    assign {condTrue, pcChange, skipTaken, progWord} = cur;

    initial begin
        cur = 27'h0;
        progValid = 1'b0;
    end

    // acceptance as the decoder saw it
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) took <= 1'b0;
        else took <= progValid && fetchReady;
    end

    // an offered word is held until taken, never withdrawn;
    // idle lines flip each cycle so stale values cannot pass
    always @(negedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr <= 7'h0;
            bub <= 1'b0;
            progValid <= 1'b0;
            cur <= 27'h0;
        end else if (!progValid || took) begin
            nxt = took ? ptr + 7'h1 : ptr;
            ptr <= nxt;
            bub <= stall && !bub;
            if (start && nxt < progLen && !(stall && bub)) begin
                cur <= prog[nxt];
                progValid <= 1'b1;
            end else begin
                cur <= ~cur;
                progValid <= 1'b0;
            end
        end
    end
endmodule

// ===== sim/instruction_format_timing_bench.sv
// self-checking bench for the instruction decoder and sequencer
`timescale 1ns/1ps

module instruction_format_timing_bench;
    import ifd_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic stall = 1'b0;
    logic [23:0] progWord;
    logic progValid, condTrue, pcChange, skipTaken, fetchReady;
    logic issueValid, accumulator_alias, bitIndirect, targetIsFile;
    logic cycleNop, secondBad;
    logic [7:0] issueOpcode;
    ifd_class_e issueClass;
    ifd_mode_e secondSourceMode, destMode;
    logic [3:0] base_source_reg, second_source_reg, dest_reg, bitPos;
    logic [12:0] fileAddr;
    logic [15:0] literal, extOperand;
    logic [26:0] prog [64]; // program image for the fetch model
    logic [6:0] progLen = 7'h0;
    logic [23:0] eW[$], eX[$]; // expected words, second words
    int eG[$]; // expected cycles since the previous issue
    int n_fail = 0, comparisons = 0, cyc = 0, lastCyc = -1, prevPad;
    int nopCnt = 0; // no-op cycles seen since the previous issue
    int seed = 32'hd8b20229;
    bit skipNext, gapOn;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    ifd_core u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .progWord(progWord), .progValid(progValid), .condTrue(condTrue),
        .pcChange(pcChange), .skipTaken(skipTaken),
        .fetchReady(fetchReady), .issueValid(issueValid),
        .issueOpcode(issueOpcode), .issueClass(issueClass),
        .base_source_reg(base_source_reg),
        .second_source_reg(second_source_reg),
        .secondSourceMode(secondSourceMode), .dest_reg(dest_reg),
        .destMode(destMode), .fileAddr(fileAddr),
        .accumulator_alias(accumulator_alias), .bitPos(bitPos),
        .bitIndirect(bitIndirect), .targetIsFile(targetIsFile),
        .literal(literal), .extOperand(extOperand),
        .cycleNop(cycleNop), .secondBad(secondBad));

    ifd_fetch_model u_mem (.core_clk(core_clk), .arst_n(arst_n),
        .fetchReady(fetchReady), .start(start), .stall(stall),
        .prog(prog), .progLen(progLen), .progWord(progWord),
        .progValid(progValid), .condTrue(condTrue),
        .pcChange(pcChange), .skipTaken(skipTaken));

    // category picked by the opcode byte
    function automatic ifd_class_e clsOf(input logic [7:0] op);
        case (op[7:4])
            4'h5: return CL_FILE;
            4'h6: return CL_BIT;
            4'h7: return CL_LITMOV;
            4'h8: return CL_LITALU;
            4'h9: return CL_SKIP;
            4'h0: begin
                case (op[3:0])
                    4'h2, 4'h3, 4'h4: return CL_TWOWORD;
                    4'h5: return CL_BRANCH;
                    4'h6: return CL_INDJMP;
                    4'h7, 4'h8: return CL_TABLE;
                    4'h9, 4'ha: return CL_RETURN;
                    default: return CL_NOP;
                endcase
            end
            default: return CL_WORD;
        endcase
    endfunction

    // padding cycles after the issue; f is a true test or jump
    function automatic int padOf(input ifd_class_e c, input logic f);
        case (c)
            CL_RETURN: return 2;
            CL_BRANCH, CL_INDJMP, CL_TABLE: return 1;
            CL_NOP, CL_TWOWORD, CL_SKIP: return 0;
            default: return int'(f);
        endcase
    endfunction

    task automatic chk(input string n, input logic [23:0] e,
                       input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // append one instruction and what its issue should show
    task automatic instr(input logic [23:0] w, input logic f,
                         input logic [23:0] w2);
        ifd_class_e c;
        int n;
        logic cd;
        logic fl;
        c = clsOf(w[23:16]);
        n = (c == CL_TWOWORD) ? 2 : 1;
        // a lone second word gets the flags too, yet must not pad
        fl = f && c inside {CL_WORD, CL_FILE, CL_BIT, CL_LITMOV, CL_LITALU,
            CL_NOP};
        cd = fl && c != CL_NOP;
        prog[progLen] = {fl && w[0], fl && !w[0], f && c == CL_SKIP, w};
        progLen++;
        if (n == 2) begin
            prog[progLen] = {3'b000, w2};
            progLen++;
        end
        // skipped words cost the skip one cycle each
        if (skipNext) begin
            prevPad += n;
            skipNext = 0;
        end else begin
            eW.push_back(w);
            eX.push_back(n == 2 ? w2 : 24'h0);
            eG.push_back(prevPad + n);
            prevPad = padOf(c, cd);
            skipNext = f && c == CL_SKIP;
        end
    endtask

    task automatic checkIssue(input logic [23:0] w, input logic [23:0] x,
                              input int gp);
        logic [15:0] o;
        ifd_class_e c;
        o = w[15:0];
        c = clsOf(w[23:16]);
        chk("opcode", {16'h0, w[23:16]}, {16'h0, issueOpcode});
        chk("class", {20'h0, c}, {20'h0, issueClass});
        if (gapOn && lastCyc >= 0)
            chk("gap", 24'(gp), 24'(cyc - lastCyc));
        if (gapOn && lastCyc >= 0)
            chk("nops", 24'(gp - (c == CL_TWOWORD ? 2 : 1)),
                24'(nopCnt));
        chk("ext", {8'h0, x[15:0]}, {8'h0, extOperand});
        chk("bad", {23'h0, x[23:16] != 8'h0}, {23'h0, secondBad});
        case (c)
            CL_WORD, CL_SKIP: chk("word", {8'h0, o}, {8'h0,
                base_source_reg, dest_reg,
                destMode, secondSourceMode, second_source_reg});
            CL_FILE: chk("file", {10'h0, o[15], o[12:0]},
                {10'h0, accumulator_alias, fileAddr});
            CL_BIT: begin
                chk("bit", {18'h0, o[15:10]}, {18'h0, targetIsFile,
                    bitIndirect, o[14] ? base_source_reg : bitPos});
                chk("bitreg", {5'h0, 3'h0, o[9:0], o[5:0]}, {5'h0, fileAddr,
                    secondSourceMode, second_source_reg});
            end
            CL_LITMOV: begin
                chk("litmov", {7'h0, o[15], 5'h0, o[14:4]},
                    {7'h0, targetIsFile, literal});
                chk("littgt", {20'h0, o[3:0]}, {20'h0, dest_reg});
            end
            CL_LITALU: begin
                chk("litalu", {8'h0, o[15:12],
                    o[5] ? o[11:8] : o[15:12], 3'h0, o[4:0]}, {8'h0,
                    base_source_reg, dest_reg, literal[7:0]});
                chk("litmode", {22'h0, o[5] ? o[7:6] : 2'h0},
                    {22'h0, destMode});
            end
            default: chk("addr", {8'h0, o}, {8'h0, literal});
        endcase
    endtask

    // issue monitor, sampled where outputs are settled
    always @(negedge core_clk) begin
        if (arst_n === 1'b1 && issueValid === 1'b1) begin
            if (eW.size() == 0) chk("extra", 24'h0, 24'h1);
            else checkIssue(eW.pop_front(), eX.pop_front(), eG.pop_front());
            lastCyc = cyc;
            nopCnt = 0;
        end
        // the issue cycle itself opens the next window
        if (cycleNop === 1'b1) nopCnt++;
    end

    // one reset, corner cases, random stream, drain
    task automatic phase(input int nRand, input logic slow);
        int i;
        logic [31:0] r;
        arst_n = 1'b0;
        stall = slow;
        gapOn = !slow;
        progLen = 7'h0;
        prevPad = 0;
        skipNext = 0;
        lastCyc = -1;
        // control opcodes 00 to 0b, lone second word included
        for (i = 0; i < 12; i++) begin
            r = $random(seed);
            instr({i[7:0], r[15:0]}, 1'b1, {8'h0, r[31:16]});
        end
        instr(24'h031234, 1'b0, 24'h5a0000);
        instr(24'h91aaaa, 1'b1, 24'h0);
        instr(24'h12c3a5, 1'b1, 24'h0);
        instr(24'h935555, 1'b1, 24'h0);
        instr(24'h02abcd, 1'b0, 24'h00ffff);
        instr(24'h940001, 1'b0, 24'h0);
        for (i = 0; i < nRand; i++) begin
            r = $random(seed);
            instr(r[23:0], r[24], {r[31:27] == 5'h0 ? r[7:0] : 8'h0,
                r[31:16]});
        end
        instr(24'h4a5a5a, 1'b0, 24'h0);
        start = 1'b1;
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        i = 0;
        while (eW.size() > 0 && i < 2000) begin
            @(negedge core_clk);
            i++;
        end
        chk("left", 24'h0, 24'(eW.size()));
        repeat (6) @(negedge core_clk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        phase(12, 1'b0);
        phase(12, 1'b1);
        end_sim();
    end

    // both phases need well under 1500 cycles
    initial begin
        #60000;
        n_fail++;
        end_sim();
    end
endmodule
